// ---- hdl/obdcs_regs.svh ----
`ifndef OBDCS_REGS_SVH
`define OBDCS_REGS_SVH

// ==================================================================
// Register offsets
`define OBDCS_OFS_CTRL      8'h00
`define OBDCS_OFS_RESP_TO   8'h04
`define OBDCS_OFS_ACT_TO    8'h08
`define OBDCS_OFS_ACT_CNT   8'h0c
`define OBDCS_OFS_RX_ADDR   8'h10
`define OBDCS_OFS_HEADER    8'h14
`define OBDCS_OFS_STATUS    8'h18
`define OBDCS_OFS_LIMITS    8'h1c

// ==================================================================
// Control field positions
`define OBDCS_B_LONG        0
`define OBDCS_B_ADAPT_LO    1
`define OBDCS_B_ADAPT_HI    2
`define OBDCS_B_AUTO_RX     3
`define OBDCS_B_CONFIRM     4
`define OBDCS_B_AUTOFMT     5
`define OBDCS_B_FLOW        6
`define OBDCS_B_SILENT      7
`define OBDCS_B_CAN_X5      8
`define OBDCS_B_HEAVY_X5    9
`define OBDCS_B_DLC_PRINT   10
`define OBDCS_B_VAR_DLC     11
`define OBDCS_B_J1939       12
`define OBDCS_B_SLEEP_OPT   13
`define OBDCS_B_MONITOR     14
`define OBDCS_CTRL_W        15

// ==================================================================
// Reset values
`define OBDCS_RST_CTRL      15'h00fa
`define OBDCS_RST_RESP_TO   8'h32
`define OBDCS_RST_ACT_TO    8'h00
`define OBDCS_RST_RX_ADDR   8'hf1
`define OBDCS_RST_HEADER    24'h686af1

// ==================================================================
// Timing
`define OBDCS_CLK_NS        25
`define OBDCS_AM_TICK_NS    655360000
`define OBDCS_TO_TICK_NS    4000000
`define OBDCS_J1939_TO      8'hc8
`define OBDCS_SLEEP_ALT_TO  8'hff
`define OBDCS_CMD_DEPTH     16
`define OBDCS_CHAR_CR       8'h0d

`endif

// ---- hdl/obdcs_pkg.sv ----
package obdcs_pkg;

   // ===============================================================
   // Types
   typedef struct packed {
      logic       send_confirm_on;
      logic       auto_formatting_on;
      logic       flow_reply_on;
      logic       silent_listen_on;
      logic       can_timer_times_five;
      logic       heavy_timer_times_five;
      logic       length_code_print;
      logic       variable_length;
      logic       j1939;
   } obdcs_can_opts_t;

   typedef struct packed {
      logic       valid;
      logic       is_can;
      logic       insert;
      logic [3:0] len;
   } obdcs_tx_req_t;

   typedef struct packed {
      logic       valid;
      logic       replay;
      logic       is_at;
      logic [4:0] len;
   } obdcs_cmd_t;

   typedef enum logic {
      OBDCS_IDLE,
      OBDCS_WAIT
   } obdcs_rsp_fsm_t;

endpackage

// ---- hdl/obdcs_core.sv ----
//
// Contract
// - Bare carriage return replays the most recent executed command.
// - Without long option, sent and received messages limited to seven bytes.
// - Long option allows eight-byte sends and unlimited receives.
// - CAN eight-byte sends allowed; inserted byte drops the eighth byte.
// - Activity counter clears on activity, else advances every 0.655 s.
// - Activity counter saturates at FF and holds 00 while monitoring.
// - Nonzero timeout hh raises alarm after (hh+1) x 0.65536 s idle.
// - Timeout 00 blocks every low power output of the monitor.
// - Sleep period chosen by sleep option bit or timeout value.
// - Vehicle response accepted only when destination equals receive address.
// - Auto mode derives receive address from header, recomputed on change.
// - Auto receive on after reset, not applied under J1939.
// - Adaptive timeout learns response times, never exceeds programmed value.
// - Adaptive modes: disabled, moderate default, aggressive.
// - J1939 ignores adaptive timing, uses fixed timeout.
// - Reset: confirmation, auto format, flow replies, silent monitor all on.
// - CAN and J1939 timer multipliers select 1 or 5, default 1.
// - Reset: length code printing and variable length code off.
// - Programmed timeout equals hh times 4 ms, bounding adaptive choice.
// - AT commands collected and executed only on terminating return.
`timescale 1ns/100ps
`default_nettype none
`include "obdcs_regs.svh"

module obdcs_core
   import obdcs_pkg::*;
#(
   parameter int AM_TICK_CYC = `OBDCS_AM_TICK_NS / `OBDCS_CLK_NS,
   parameter int TO_TICK_CYC = `OBDCS_TO_TICK_NS / `OBDCS_CLK_NS
) (
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            rst_n,
   // Register port
   input  wire logic [7:0]      addr,
   input  wire logic [31:0]     wdata,
   input  wire logic            wr,
   input  wire logic            rd,
   output logic      [31:0]     rdata,
   // Host characters from the serial receiver
   input  wire logic            rx_char_valid,
   input  wire logic [7:0]      rx_char,
   input  wire logic [3:0]      cmd_rd_idx,
   output obdcs_cmd_t           cmd,
   output logic      [7:0]      cmd_rd_char,
   // Vehicle side
   input  wire logic            bus_activity,
   input  wire logic            msg_valid,
   input  wire logic [7:0]      msg_dest,
   input  wire logic            msg_byte_valid,
   input  wire logic [7:0]      msg_byte_idx,
   input  wire obdcs_tx_req_t   tx_req,
   input  wire logic            req_sent,
   input  wire logic            resp_seen,
   output logic                 msg_accept,
   output logic                 byte_keep,
   output logic      [3:0]      tx_send_len,
   output logic                 tx_refuse,
   output logic                 resp_timeout,
   output logic                 act_alarm,
   output obdcs_can_opts_t      can_opts
);

   // ===============================================================
   // Helpers
   function automatic logic [7:0] min8(input logic [7:0] a,
                                       input logic [7:0] b);
      min8 = (a < b) ? a : b;
   endfunction

   function automatic logic is_letter(input logic [7:0] c,
                                      input logic [7:0] up);
      is_letter = (c == up) || (c == (up | 8'h20));
   endfunction

   // ===============================================================
   // Registers
   logic [`OBDCS_CTRL_W-1:0] ctrl_q;
   logic [7:0]               resp_to_q;
   logic [7:0]               act_to_q;
   logic [7:0]               user_addr_q;
   logic                     user_set_q;
   logic [23:0]              header_q;
   logic [7:0]               act_cnt_q;
   logic                     act_over_q;
   logic [7:0]               rx_addr_q;
   logic [7:0]               learned_q;
   logic [7:0]               eff_to;
   logic                     long_on;
   logic                     j1939_on;
   logic                     monitoring;
   logic [1:0]               adapt_mode;

   assign long_on    = ctrl_q[`OBDCS_B_LONG];
   assign j1939_on   = ctrl_q[`OBDCS_B_J1939];
   assign monitoring = ctrl_q[`OBDCS_B_MONITOR];
   assign adapt_mode = ctrl_q[`OBDCS_B_ADAPT_HI:`OBDCS_B_ADAPT_LO];

   // Control and settings writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_q    <= `OBDCS_RST_CTRL;
         resp_to_q <= `OBDCS_RST_RESP_TO;
         act_to_q  <= `OBDCS_RST_ACT_TO;
         header_q  <= `OBDCS_RST_HEADER;
      end else if (wr) begin
         if (addr == `OBDCS_OFS_CTRL)
            ctrl_q <= wdata[`OBDCS_CTRL_W-1:0];
         if (addr == `OBDCS_OFS_RESP_TO)
            resp_to_q <= wdata[7:0];
         if (addr == `OBDCS_OFS_ACT_TO)
            act_to_q <= wdata[7:0];
         if (addr == `OBDCS_OFS_HEADER)
            header_q <= wdata[23:0];
      end
   end

   // User receive address
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         user_addr_q <= `OBDCS_RST_RX_ADDR;
         user_set_q  <= 1'b0;
      end else if (wr && addr == `OBDCS_OFS_RX_ADDR) begin
         user_addr_q <= wdata[7:0];
         user_set_q  <= wdata[8];
      end
   end

   assign can_opts = '{
      send_confirm_on:        ctrl_q[`OBDCS_B_CONFIRM],
      auto_formatting_on:     ctrl_q[`OBDCS_B_AUTOFMT],
      flow_reply_on:          ctrl_q[`OBDCS_B_FLOW],
      silent_listen_on:       ctrl_q[`OBDCS_B_SILENT],
      can_timer_times_five:   ctrl_q[`OBDCS_B_CAN_X5],
      heavy_timer_times_five: ctrl_q[`OBDCS_B_HEAVY_X5],
      length_code_print:      ctrl_q[`OBDCS_B_DLC_PRINT],
      variable_length:        ctrl_q[`OBDCS_B_VAR_DLC],
      j1939:                  j1939_on};

   // Read data, one cycle after the strobe
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         unique case (addr)
            `OBDCS_OFS_CTRL:    rdata <= {17'h0, ctrl_q};
            `OBDCS_OFS_RESP_TO: rdata <= {24'h0, resp_to_q};
            `OBDCS_OFS_ACT_TO:  rdata <= {24'h0, act_to_q};
            `OBDCS_OFS_ACT_CNT: rdata <= {24'h0, act_cnt_q};
            `OBDCS_OFS_RX_ADDR: rdata <= {23'h0, user_set_q, rx_addr_q};
            `OBDCS_OFS_HEADER:  rdata <= {8'h0, header_q};
            `OBDCS_OFS_STATUS:  rdata <= {16'h0, eff_to, 7'h0, act_alarm};
            `OBDCS_OFS_LIMITS:  rdata <= {31'h0, long_on};
            default:            rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // ===============================================================
   // Command collection
   logic [7:0] buf_q [`OBDCS_CMD_DEPTH];
   logic [7:0] last_q [`OBDCS_CMD_DEPTH];
   logic [4:0] fill_q;
   logic [4:0] last_len_q;
   logic       is_cr;

   assign is_cr = rx_char_valid && rx_char == `OBDCS_CHAR_CR;

   // Gather characters until the return arrives
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fill_q <= 5'h00;
      end else if (is_cr) begin
         fill_q <= 5'h00;
      end else if (rx_char_valid && rx_char >= 8'h20
                   && fill_q < 5'(`OBDCS_CMD_DEPTH)) begin
         buf_q[fill_q[3:0]] <= rx_char;
         fill_q             <= fill_q + 5'h01;
      end
   end

   // Keep the last executed command for replay
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         last_len_q <= 5'h00;
      end else if (is_cr && fill_q != 5'h00) begin
         last_q     <= buf_q;
         last_len_q <= fill_q;
      end
   end

   // Execute pulse, replay on a bare return
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cmd <= '0;
      end else if (is_cr) begin
         cmd.valid  <= (fill_q != 5'h00) || (last_len_q != 5'h00);
         cmd.replay <= (fill_q == 5'h00);
         cmd.len    <= (fill_q == 5'h00) ? last_len_q : fill_q;
         cmd.is_at  <= (fill_q == 5'h00) ?
            (last_len_q > 5'h01 && is_letter(last_q[0], 8'h41)
             && is_letter(last_q[1], 8'h54)) :
            (fill_q > 5'h01 && is_letter(buf_q[0], 8'h41)
             && is_letter(buf_q[1], 8'h54));
      end else begin
         cmd.valid <= 1'b0;
      end
   end

   // Character of the executed command, from the replay copy
   always_ff @(posedge clock) begin
      if (!rst_n)
         cmd_rd_char <= 8'h00;
      else
         cmd_rd_char <= last_q[cmd_rd_idx];
   end

   // ===============================================================
   // Message length limits
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_send_len <= 4'h0;
         tx_refuse   <= 1'b0;
         byte_keep   <= 1'b0;
      end else begin
         if (tx_req.valid) begin
            if (tx_req.is_can && tx_req.len <= 4'h8) begin
               tx_refuse   <= 1'b0;
               tx_send_len <= (tx_req.insert && tx_req.len == 4'h8) ?
                              4'h7 : tx_req.len;
            end else if (tx_req.len <= (long_on ? 4'h8 : 4'h7)) begin
               tx_refuse   <= 1'b0;
               tx_send_len <= tx_req.len;
            end else begin
               tx_refuse   <= 1'b1;
               tx_send_len <= 4'h0;
            end
         end
         byte_keep <= msg_byte_valid
                      && (long_on || msg_byte_idx < 8'h07);
      end
   end

   // ===============================================================
   // Receive address selection and filter
   always_ff @(posedge clock) begin
      if (!rst_n)
         rx_addr_q <= `OBDCS_RST_RX_ADDR;
      else if (!ctrl_q[`OBDCS_B_AUTO_RX] || j1939_on || user_set_q)
         rx_addr_q <= user_addr_q;
      else if (header_q[18])
         rx_addr_q <= header_q[7:0];
      else
         rx_addr_q <= header_q[15:8] + 8'h01;
   end

   always_ff @(posedge clock) begin
      if (!rst_n)
         msg_accept <= 1'b0;
      else
         msg_accept <= msg_valid && msg_dest == rx_addr_q;
   end

   // ===============================================================
   // Activity monitor
   logic        act_s1_q;
   logic        act_s2_q;
   logic        act_s3_q;
   logic [31:0] am_div_q;
   logic        am_tick;
   logic        activity;
   logic [8:0]  act_lvl;
   logic [7:0]  sleep_to;

   // Pin synchroniser and edge detect
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         act_s1_q <= 1'b0;
         act_s2_q <= 1'b0;
         act_s3_q <= 1'b0;
      end else begin
         act_s1_q <= bus_activity;
         act_s2_q <= act_s1_q;
         act_s3_q <= act_s2_q;
      end
   end
   assign activity = act_s2_q ^ act_s3_q;

   // Tick divider, restarted by activity
   always_ff @(posedge clock) begin
      if (!rst_n || activity || am_tick)
         am_div_q <= 32'h0;
      else
         am_div_q <= am_div_q + 32'h1;
   end
   assign am_tick = am_div_q == 32'(AM_TICK_CYC - 1);

   // Saturating activity counter
   always_ff @(posedge clock) begin
      if (!rst_n || activity || monitoring) begin
         act_cnt_q  <= 8'h00;
         act_over_q <= 1'b0;
      end else if (am_tick) begin
         if (act_cnt_q == 8'hff)
            act_over_q <= 1'b1;
         else
            act_cnt_q <= act_cnt_q + 8'h01;
      end
   end

   assign act_lvl  = {act_over_q, act_cnt_q};
   assign sleep_to = ctrl_q[`OBDCS_B_SLEEP_OPT] ?
                     `OBDCS_SLEEP_ALT_TO : act_to_q;

   always_ff @(posedge clock) begin
      if (!rst_n)
         act_alarm <= 1'b0;
      else
         act_alarm <= act_to_q != 8'h00
                      && act_lvl > {1'b0, sleep_to};
   end

   // ===============================================================
   // Response timeout and adaptive timing
   obdcs_rsp_fsm_t fsm_q;
   logic [31:0]    to_div_q;
   logic           to_tick;
   logic [7:0]     wait_q;
   logic [7:0]     margin;

   assign to_tick = to_div_q == 32'(TO_TICK_CYC - 1);

   always_comb begin
      margin = (adapt_mode == 2'd2) ? (learned_q >> 2) + 8'h01
                                    : (learned_q >> 1) + 8'h02;
      if (j1939_on)
         eff_to = `OBDCS_J1939_TO;
      else if (adapt_mode == 2'd0)
         eff_to = resp_to_q;
      else
         eff_to = min8(resp_to_q,
                       (learned_q > 8'hff - margin) ? 8'hff
                       : learned_q + margin);
   end

   // Wait state
   always_ff @(posedge clock) begin
      if (!rst_n)
         fsm_q <= OBDCS_IDLE;
      else
         unique case (fsm_q)
            OBDCS_IDLE: if (req_sent) fsm_q <= OBDCS_WAIT;
            OBDCS_WAIT: if (resp_seen || resp_timeout
                            || wait_q >= eff_to) fsm_q <= OBDCS_IDLE;
         endcase
   end

   // 4 ms units since the request
   always_ff @(posedge clock) begin
      if (!rst_n || fsm_q == OBDCS_IDLE || to_tick)
         to_div_q <= 32'h0;
      else
         to_div_q <= to_div_q + 32'h1;
   end

   always_ff @(posedge clock) begin
      if (!rst_n || fsm_q == OBDCS_IDLE)
         wait_q <= 8'h00;
      else if (to_tick && wait_q != 8'hff)
         wait_q <= wait_q + 8'h01;
   end

   // Timeout pulse after eff_to x 4 ms
   always_ff @(posedge clock) begin
      if (!rst_n)
         resp_timeout <= 1'b0;
      else
         resp_timeout <= fsm_q == OBDCS_WAIT && !resp_seen
                         && !resp_timeout && wait_q >= eff_to;
   end

   // Learn from measured replies
   always_ff @(posedge clock) begin
      if (!rst_n)
         learned_q <= 8'h00;
      else if (fsm_q == OBDCS_WAIT && resp_seen)
         learned_q <= (wait_q > learned_q) ? wait_q
                      : learned_q - ((learned_q - wait_q) >> 2);
   end

   // ===============================================================
   // Checks
   chk_adapt_bound: assert property (@(posedge clock) disable iff (!rst_n)
      !j1939_on |-> eff_to <= resp_to_q)
      else $error("adaptive timeout above programmed value");
   chk_j1939_fixed: assert property (@(posedge clock) disable iff (!rst_n)
      j1939_on |-> eff_to == `OBDCS_J1939_TO)
      else $error("j1939 timeout not fixed");
   chk_am_zero_block: assert property (@(posedge clock) disable iff (!rst_n)
      $past(act_to_q) == 8'h00 |-> !act_alarm)
      else $error("alarm with zero timeout");
   chk_monitor_hold: assert property (@(posedge clock) disable iff (!rst_n)
      monitoring [*2] |-> act_cnt_q == 8'h00)
      else $error("activity count moved while monitoring");
   chk_act_clear: assert property (@(posedge clock) disable iff (!rst_n)
      activity |=> act_cnt_q == 8'h00)
      else $error("activity did not clear counter");
   chk_act_step: assert property (@(posedge clock) disable iff (!rst_n)
      !activity && !monitoring && !$past(monitoring) && !am_tick
      |=> $stable(act_cnt_q))
      else $error("activity count moved without tick");
   chk_addr_filter: assert property (@(posedge clock) disable iff (!rst_n)
      msg_accept |-> $past(msg_valid) && $past(msg_dest) == $past(rx_addr_q))
      else $error("accept without address match");
   chk_short_keep: assert property (@(posedge clock) disable iff (!rst_n)
      msg_byte_valid && !long_on && msg_byte_idx >= 8'h07 |=> !byte_keep)
      else $error("byte kept beyond seven");
   chk_can_insert: assert property (@(posedge clock) disable iff (!rst_n)
      tx_req.valid && tx_req.is_can && tx_req.insert && tx_req.len == 4'h8
      |=> tx_send_len == 4'h7 && !tx_refuse)
      else $error("inserted byte not dropping data");
   chk_replay_cmd: assert property (@(posedge clock) disable iff (!rst_n)
      is_cr && fill_q == 5'h00 && last_len_q != 5'h00
      |=> cmd.valid && cmd.replay && cmd.len == $past(last_len_q))
      else $error("bare return did not replay");
   chk_cmd_on_cr: assert property (@(posedge clock) disable iff (!rst_n)
      cmd.valid |-> $past(is_cr))
      else $error("command ran without return");
   cov_replay: cover property (@(posedge clock) disable iff (!rst_n)
      cmd.valid && cmd.replay);
   cov_alarm: cover property (@(posedge clock) disable iff (!rst_n)
      $rose(act_alarm));
   cov_timeout: cover property (@(posedge clock) disable iff (!rst_n)
      resp_timeout);
   cov_accept: cover property (@(posedge clock) disable iff (!rst_n)
      msg_accept);

endmodule // obdcs_core

`default_nettype wire

// ---- verif/obdcs_vehicle.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// Vehicle bus stand-in
module obdcs_vehicle (
   // Clock
   input  wire logic       clock,
   // Requests
   input  wire logic       req_sent,
   input  wire logic       kick,
   input  wire logic [7:0] lat,
   // Vehicle lines
   output logic            bus_activity,
   output logic            resp_seen
);
   logic       pin_q = 1'b0;
   logic [7:0] wait_q = 8'h00;
   assign bus_activity = pin_q;
   // Edge on the pin for each kick
   always @(posedge clock) if (kick) pin_q <= !pin_q;
   // Answer after lat cycles, zero stays silent
   always @(posedge clock) begin
      resp_seen <= (wait_q == 8'h01);
      if (req_sent && lat != 8'h00) wait_q <= lat;
      else if (wait_q != 8'h00) wait_q <= wait_q - 8'h01;
   end
endmodule // obdcs_vehicle
`default_nettype wire

// ---- verif/obd_at_command_settings_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "obdcs_regs.svh"
// ==========
// Bench top
module obd_at_command_settings_test
   import obdcs_pkg::*;
;
   logic clock, rst_n, wr, rd, rx_char_valid, msg_valid, msg_byte_valid;
   logic req_sent, kick, bus_activity, resp_seen, msg_accept, byte_keep;
   logic tx_refuse, resp_timeout, act_alarm;
   logic [7:0]      addr, rx_char, msg_dest, msg_byte_idx, lat, cmd_rd_char;
   logic [31:0]     wdata, rdata, v;
   logic [3:0]      cmd_rd_idx, tx_send_len;
   logic [15:0]     rnd;
   logic [4:0]      e;
   logic [23:0]     hdr [4] = '{24'h686af1, 24'h6c6a10, 24'h686cf1, 24'h6c6a10};
   obdcs_tx_req_t   tx_req, t;
   obdcs_cmd_t      cmd, c;
   obdcs_can_opts_t can_opts;
   int              n_errors, checked, cyc, i, n;

   // Design and vehicle model
   obdcs_core #(.AM_TICK_CYC(8), .TO_TICK_CYC(4)) uut (.clock(clock),
      .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .cmd_rd_idx(cmd_rd_idx), .cmd(cmd), .cmd_rd_char(cmd_rd_char),
      .bus_activity(bus_activity), .msg_valid(msg_valid),
      .msg_dest(msg_dest), .msg_byte_valid(msg_byte_valid),
      .msg_byte_idx(msg_byte_idx), .tx_req(tx_req), .req_sent(req_sent),
      .resp_seen(resp_seen), .msg_accept(msg_accept), .byte_keep(byte_keep),
      .tx_send_len(tx_send_len), .tx_refuse(tx_refuse),
      .resp_timeout(resp_timeout), .act_alarm(act_alarm),
      .can_opts(can_opts));
   obdcs_vehicle veh (.clock(clock), .req_sent(req_sent), .kick(kick),
      .lat(lat), .bus_activity(bus_activity), .resp_seen(resp_seen));

   // Clock and hang guard
   always #12.5 clock = !clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         n_errors++;
         finish_test;
      end
   end

   // ==========
   // Helpers
   task automatic chk(input string nm, input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("checked %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      d = rdata;
   endtask
   task automatic put_char(input logic [7:0] ch);
      @(posedge clock);
      rx_char_valid <= 1'b1;
      rx_char <= ch;
      @(posedge clock);
      rx_char_valid <= 1'b0;
   endtask
   task automatic wait_cmd;
      c = '0;
      for (n = 0; n < 10 && c.valid !== 1'b1; n++) begin
         @(negedge clock);
         c = cmd;
      end
   endtask
   // Kind 0 message, 1 data byte, 2 transmit request
   task automatic vstrobe(input int k, input logic [7:0] a,
                          input obdcs_tx_req_t tr);
      @(posedge clock);
      msg_valid <= (k == 0);
      msg_byte_valid <= (k == 1);
      msg_dest <= a;
      msg_byte_idx <= a;
      tx_req <= tr;
      @(posedge clock);
      msg_valid <= 1'b0;
      msg_byte_valid <= 1'b0;
      tx_req.valid <= 1'b0;
      @(negedge clock);
   endtask
   task automatic pulse(input int k);
      @(posedge clock);
      if (k == 0) kick <= 1'b1;
      else req_sent <= 1'b1;
      @(posedge clock);
      kick <= 1'b0;
      req_sent <= 1'b0;
      for (n = 0; k == 1 && n < 600 && resp_timeout !== 1'b1; n++)
         @(negedge clock);
   endtask
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Refuse flag above the length that goes out
   function automatic logic [4:0] tx_exp(obdcs_tx_req_t r, logic lng);
      if (r.is_can)
         return r.len > 4'h8 ? 5'h10 : (r.insert && r.len == 4'h8) ? 5'h07
                                                          : {1'b0, r.len};
      return r.len > (lng ? 4'h8 : 4'h7) ? 5'h10 : {1'b0, r.len};
   endfunction
   function automatic logic [7:0] rx_exp(logic [23:0] h, logic j);
      if (j) return `OBDCS_RST_RX_ADDR;
      return h[18] ? h[7:0] : h[15:8] + 8'h01;
   endfunction

   // ==========
   // Main sequence
   initial begin
      {clock, wr, rd, rx_char_valid, msg_valid, msg_byte_valid} = '0;
      {req_sent, kick, rst_n, addr, wdata, rx_char, msg_dest} = '0;
      {msg_byte_idx, lat, cmd_rd_idx, tx_req} = '0;
      {n_errors, checked, cyc} = '0;
      rnd = 16'h0010;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      rd_reg(`OBDCS_OFS_CTRL, v);
      chk("ctrl", v, 32'h00fa);
      chk("can_opts", can_opts, 9'h1e0);
      rd_reg(`OBDCS_OFS_RESP_TO, v);
      chk("resp_to", v, 32'h32);
      wr_reg(8'h20, 32'hffff);
      rd_reg(8'h20, v);
      chk("unmapped", v, 32'h0);
      $display("reset test done");
      // Command then bare return
      for (i = 0; i < 3; i++) put_char(i == 0 ? "A" : i == 1 ? "T" : "Z");
      @(negedge clock);
      chk("early", cmd.valid, 1'b0);
      put_char(8'h0d);
      wait_cmd;
      chk("cmd", {c.valid, c.replay, c.is_at, c.len}, 8'ha3);
      @(negedge clock);
      chk("text", cmd_rd_char, "A");
      @(posedge clock);
      cmd_rd_idx <= 4'h2;
      repeat (2) @(negedge clock);
      chk("text2", cmd_rd_char, "Z");
      put_char(8'h0d);
      wait_cmd;
      chk("replay", {c.valid, c.replay, c.len}, 7'h63);
      put_char("0");
      put_char("1");
      put_char(8'h0d);
      wait_cmd;
      chk("not_at", {c.valid, c.is_at, c.len}, 7'h42);
      $display("command test done");
      // Random transmit lengths, long option on in the second half
      for (i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         if (i == 20) wr_reg(`OBDCS_OFS_CTRL, 32'h00fb);
         t = '{1'b1, rnd[0], rnd[1], rnd[5:2]};
         if (i == 0 || i == 21) t = '{1'b1, 1'b1, 1'b1, 4'h8};
         if (i == 1 || i == 22) t = '{1'b1, 1'b0, 1'b0, 4'h8};
         vstrobe(2, 8'h00, t);
         e = tx_exp(t, i >= 20);
         chk("tx_refuse", tx_refuse, e[4]);
         if (!e[4]) chk("tx_len", tx_send_len, e[3:0]);
      end
      for (i = 0; i < 4; i++) begin
         if (i == 2) wr_reg(`OBDCS_OFS_CTRL, 32'h00fa);
         vstrobe(1, i == 0 ? 8'hc8 : i == 2 ? 8'h06 : 8'h07, '0);
         chk("keep", byte_keep, i < 3);
      end
      $display("length test done");
      // Receive address from header, user address under J1939
      for (i = 0; i < 4; i++) begin
         wr_reg(`OBDCS_OFS_CTRL, i == 3 ? 32'h10fa : 32'h00fa);
         wr_reg(`OBDCS_OFS_HEADER, {8'h00, hdr[i]});
         e[4:0] = 5'h0;
         rd_reg(`OBDCS_OFS_RX_ADDR, v);
         chk("rx_addr", v, rx_exp(hdr[i], i == 3));
         vstrobe(0, rx_exp(hdr[i], i == 3), '0);
         chk("accept", msg_accept, 1'b1);
         vstrobe(0, rx_exp(hdr[i], i == 3) ^ 8'h01, '0);
         chk("reject", msg_accept, 1'b0);
      end
      $display("address test done");
      // Fixed and adaptive response timeouts
      wr_reg(`OBDCS_OFS_CTRL, 32'h00f8);
      wr_reg(`OBDCS_OFS_RESP_TO, 32'h02);
      pulse(1);
      chk("to_win", n inside {[6:12]}, 1'b1);
      wr_reg(`OBDCS_OFS_RESP_TO, 32'h0a);
      lat <= 8'h03;
      for (i = 1; i < 3; i++) begin
         wr_reg(`OBDCS_OFS_CTRL, 32'h00f8 | (i << 1));
         pulse(1);
         chk("answered", n, 600);
         rd_reg(`OBDCS_OFS_STATUS, v);
         chk("eff_max", v[15:8], 8'h03 - i);
      end
      wr_reg(`OBDCS_OFS_CTRL, 32'h10fa);
      rd_reg(`OBDCS_OFS_STATUS, v);
      chk("fixed_to", v[15:8], `OBDCS_J1939_TO);
      $display("timeout test done");
      // Activity monitor
      wr_reg(`OBDCS_OFS_CTRL, 32'h00fa);
      wr_reg(`OBDCS_OFS_ACT_TO, 32'h02);
      pulse(0);
      repeat (5) @(negedge clock);
      rd_reg(`OBDCS_OFS_ACT_CNT, v);
      chk("act_clr", v, 32'h0);
      repeat (12) @(negedge clock);
      chk("alarm_lo", act_alarm, 1'b0);
      repeat (16) @(negedge clock);
      chk("alarm_hi", act_alarm, 1'b1);
      wr_reg(`OBDCS_OFS_CTRL, 32'h20fa);
      repeat (3) @(negedge clock);
      chk("sleep_opt", act_alarm, 1'b0);
      repeat (2100) @(negedge clock);
      chk("sleep_hi", act_alarm, 1'b1);
      rd_reg(`OBDCS_OFS_ACT_CNT, v);
      chk("act_sat", v, 32'hff);
      wr_reg(`OBDCS_OFS_ACT_TO, 32'h00);
      repeat (3) @(negedge clock);
      chk("blocked", act_alarm, 1'b0);
      wr_reg(`OBDCS_OFS_CTRL, 32'h40fa);
      repeat (20) @(negedge clock);
      rd_reg(`OBDCS_OFS_ACT_CNT, v);
      chk("monitor", v, 32'h0);
      $display("activity test done");
      finish_test;
   end
endmodule // obd_at_command_settings_test
`default_nettype wire
